// ==== hdl/e1fie_pkg.sv ====
/*
 * Package for the receive E1 framer interrupt enable block: register
 * offsets, field positions, reset values and the carrier structs.
 * Assumes one 125 MHz clock and a plain address/strobe register port.
 */
`default_nettype none

package e1fie_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_IRQ_STATUS  = 8'h00;
	localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h01;
	localparam logic [7:0] OFF_IRQ_CLEAR   = 8'h02;
	localparam logic [7:0] OFF_FRAME_CTRL  = 8'h03;
	localparam logic [7:0] OFF_LIVE_STATE  = 8'h04;
	localparam logic [7:0] OFF_SIG_CHG0    = 8'h05;
	localparam int         SIG_CHG_REGS    = 4;

	// Interrupt bit positions, shared by status, enable and clear
	localparam int BIT_CAS_MFA   = 7;
	localparam int BIT_NATBIT    = 6;
	localparam int BIT_ABCD      = 5;
	localparam int BIT_FAS_SHIFT = 4;
	localparam int BIT_FRAME_OOF = 3;
	localparam int BIT_MIMIC     = 2;
	localparam int BIT_CRC4      = 1;
	localparam int BIT_FAS_ERR   = 0;

	// Framing control field positions
	localparam int FC_THR_LSB = 0;
	localparam int FC_CAS_EN  = 3;

	// Live state field positions
	localparam int LS_OOF     = 0;
	localparam int LS_MFA_LOS = 1;

	// Sizes
	localparam int SIG_CHANS = 30;
	localparam int NAT_BITS  = 5;

	// Reset values
	localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
	localparam logic [2:0] RST_FAS_THR    = 3'h3;
	localparam logic       RST_CAS_EN     = 1'b0;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} e1fie_bus_t;

	// Receive framer indications, all on the block clock
	typedef struct packed {
		logic                cas_mfa_loss;  // Level: CAS multiframe lost
		logic                nat_strobe;    // Pulse: new national bits
		logic [NAT_BITS-1:0] natbits;       // Sa4..Sa8
		logic                sig_strobe;    // Pulse: new ABCD for a channel
		logic [4:0]          sig_chan;      // Channel index 0..29
		logic [3:0]          sig_abcd;
		logic                fas_shift;     // Pulse: FAS moved position
		logic                fas_ok;        // Pulse: good FAS word
		logic                fas_err;       // Pulse: errored FAS word
		logic                realign;       // Pulse: alignment regained
		logic                mimic;         // Pulse: frame mimic seen
		logic                crc4_err;      // Pulse: CRC-4 mismatch
	} e1fie_rx_t;

	// Out-of-frame threshold, zero treated as one
	function automatic logic [2:0] e1fie_thr(input logic [2:0] fas_loss_threshold);
		e1fie_thr = (fas_loss_threshold == 3'h0) ? 3'h1 : fas_loss_threshold;
	endfunction : e1fie_thr

endpackage : e1fie_pkg

`default_nettype wire

// ==== hdl/e1fie_sticky.sv ====
/*
 * Sticky flag bank: a set pulse latches a bit, a clear mask drops it.
 * Assumes set and clear come from logic on the same clock.
 */
`default_nettype none

module e1fie_sticky #(
	parameter int unsigned W = 8
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_set,
	input  wire logic [W-1:0] i_clr,
	output logic      [W-1:0] o_q
);
	import e1fie_pkg::*;

	typedef struct packed {
		logic [W-1:0] flag;
	} e1fie_stk_t;

	e1fie_stk_t s_q;
	e1fie_stk_t s_d;

	// Set wins over a clear in the same cycle
	always_comb
	begin
		s_d      = s_q;
		s_d.flag = (s_q.flag & ~i_clr) | i_set;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_q = s_q.flag;

	a_set_wins: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_set != '0) |=> ((o_q & $past(i_set)) == $past(i_set)))
		else $error("sticky set lost");

endmodule : e1fie_sticky

`default_nettype wire

// ==== hdl/e1fie_core.sv ====
/*
 * Receive E1 framer interrupt enable and status block: eight sources,
 * sticky reset-upon-read status, per-channel signaling change flags,
 * out-of-frame tracking and one level interrupt.
 * Assumes framer indications arrive on the same clock as the register port.
 */
// Added by the designer: the register offsets and the strobed register port.
`default_nettype none


module e1fie_core (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	input  wire e1fie_pkg::e1fie_bus_t i_bus,
	input  wire e1fie_pkg::e1fie_rx_t  i_rx,
	output logic [7:0]                 o_rdata,
	output logic                       o_irq,
	output logic                       o_oof
);
	import e1fie_pkg::*;

	// Block state apart from the sticky status and change flags
	typedef struct packed {
		logic [7:0]                    en;
		logic [2:0]                    fas_loss_threshold;
		logic                          cas_en;
		logic [SIG_CHANS-1:0][3:0]     abcd;
		logic [NAT_BITS-1:0]           nat;
		logic                          nat_vld;
		logic                          mfa_prev;
		logic                          oof;
		logic [2:0]                    err_cnt;
		logic [7:0]                    rdata;
		logic                          irq;
	} e1fie_core_t;

	e1fie_core_t s_q;
	e1fie_core_t s_d;

	logic [7:0]  ev;
	logic [7:0]  st_clr;
	logic [7:0]  status;
	logic [31:0] sig_set;
	logic [31:0] sig_clr;
	logic [31:0] sig_chg;
	logic        sig_in_range;
	logic        sig_diff;
	logic        err_trip;

	// Strobe for one of the thirty signaling channels; other indices ignored
	assign sig_in_range = i_rx.sig_strobe && (i_rx.sig_chan < 5'(SIG_CHANS));

	// Signaling change for a valid channel with a new ABCD value
	assign sig_diff = sig_in_range
		&& (s_q.abcd[i_rx.sig_chan] != i_rx.sig_abcd);

	// Errored FAS word that reaches the loss threshold
	assign err_trip = i_rx.fas_err
		&& ((s_q.err_cnt + 3'h1) >= e1fie_thr(s_q.fas_loss_threshold));

	// Event vector
	always_comb
	begin
		ev                = 8'h00;
		ev[BIT_CAS_MFA]   = (i_rx.cas_mfa_loss != s_q.mfa_prev);
		ev[BIT_NATBIT]    = i_rx.nat_strobe && s_q.nat_vld
			&& (i_rx.natbits != s_q.nat);
		ev[BIT_ABCD]      = s_q.cas_en && sig_diff;
		ev[BIT_FAS_SHIFT] = i_rx.fas_shift;
		ev[BIT_FRAME_OOF] = (s_d.oof != s_q.oof);
		ev[BIT_MIMIC]     = i_rx.mimic;
		ev[BIT_CRC4]      = i_rx.crc4_err;
		ev[BIT_FAS_ERR]   = i_rx.fas_err;
	end

	// Status clears on read or on a write to the clear register
	always_comb
	begin
		st_clr = 8'h00;
		if (i_bus.rd && (i_bus.addr == OFF_IRQ_STATUS))
			st_clr = 8'hFF;
		if (i_bus.wr && (i_bus.addr == OFF_IRQ_CLEAR))
			st_clr = i_bus.wdata;
	end

	// Per-channel change flags, each byte cleared by its own read
	always_comb
	begin
		sig_set = 32'h0000_0000;
		sig_clr = 32'h0000_0000;
		if (ev[BIT_ABCD])
			sig_set[i_rx.sig_chan] = 1'b1;
		for (int k = 0; k < SIG_CHG_REGS; k++)
		begin
			if (i_bus.rd && (i_bus.addr == (OFF_SIG_CHG0 + 8'(k))))
				sig_clr[8*k +: 8] = 8'hFF;
		end
	end

	e1fie_sticky #(
		.W (8)
	) u_status (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_set (ev),
		.i_clr (st_clr),
		.o_q   (status)
	);

	e1fie_sticky #(
		.W (32)
	) u_sig_chg (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_set (sig_set),
		.i_clr (sig_clr),
		.o_q   (sig_chg)
	);

	// Next state: registers, framer tracking, read data, interrupt
	always_comb
	begin
		s_d = s_q;

		// Register writes
		if (i_bus.wr)
		begin
			unique case (i_bus.addr)
				OFF_IRQ_ENABLE:
					s_d.en = i_bus.wdata;
				OFF_FRAME_CTRL:
				begin
					s_d.fas_loss_threshold   = i_bus.wdata[FC_THR_LSB +: 3];
					s_d.cas_en = i_bus.wdata[FC_CAS_EN];
				end
				default:
					s_d.en = s_q.en;
			endcase
		end

		// Previous line values for change detection
		s_d.mfa_prev = i_rx.cas_mfa_loss;
		if (i_rx.nat_strobe)
		begin
			s_d.nat     = i_rx.natbits;
			s_d.nat_vld = 1'b1;
		end
		if (sig_in_range)
			s_d.abcd[i_rx.sig_chan] = i_rx.sig_abcd;

		// Consecutive errored FAS words; bit errors alone leave oof
		if (i_rx.realign)
		begin
			s_d.oof     = 1'b0;
			s_d.err_cnt = 3'h0;
		end
		else if (i_rx.fas_ok)
			s_d.err_cnt = 3'h0;
		else if (err_trip)
		begin
			s_d.oof     = 1'b1;
			s_d.err_cnt = 3'h0;
		end
		else if (i_rx.fas_err && !s_q.oof)
			s_d.err_cnt = s_q.err_cnt + 3'h1;

		// Read data, valid in the cycle after the strobe
		s_d.rdata = 8'h00;
		if (i_bus.rd)
		begin
			if (i_bus.addr == OFF_IRQ_STATUS)
				s_d.rdata = status;
			else if (i_bus.addr == OFF_IRQ_ENABLE)
				s_d.rdata = s_q.en;
			else if (i_bus.addr == OFF_FRAME_CTRL)
				s_d.rdata = {4'h0, s_q.cas_en, s_q.fas_loss_threshold};
			else if (i_bus.addr == OFF_LIVE_STATE)
				s_d.rdata = {6'h00, s_q.mfa_prev, s_q.oof};
			else
			begin
				for (int k = 0; k < SIG_CHG_REGS; k++)
				begin
					if (i_bus.addr == (OFF_SIG_CHG0 + 8'(k)))
						s_d.rdata = sig_chg[8*k +: 8];
				end
			end
		end

		// Level interrupt from enabled sticky bits
		s_d.irq = |(status & s_q.en);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			s_q          <= '0;
			s_q.en       <= RST_IRQ_ENABLE;
			s_q.fas_loss_threshold     <= RST_FAS_THR;
			s_q.cas_en   <= RST_CAS_EN;
		end
		else
			s_q <= s_d;
	end

	assign o_rdata = s_q.rdata;
	assign o_irq   = s_q.irq;
	assign o_oof   = s_q.oof;

	// Assertions
	a_mfa_change: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_rx.cas_mfa_loss != s_q.mfa_prev) |=> status[BIT_CAS_MFA])
		else $error("CAS multiframe change not latched");

	a_natbit_change: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_rx.nat_strobe && s_q.nat_vld && (i_rx.natbits != s_q.nat))
		|=> status[BIT_NATBIT])
		else $error("national bit change not latched");

	a_abcd_change: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_q.cas_en && sig_diff) |=> (status[BIT_ABCD] && sig_chg[$past(i_rx.sig_chan)]))
		else $error("signaling change not latched");

	a_abcd_gated: assert property (@(posedge i_clk) disable iff (i_rst)
		(!s_q.cas_en && !status[BIT_ABCD]) |=> !status[BIT_ABCD]
		&& ((sig_chg & ~$past(sig_chg)) == 32'h0000_0000))
		else $error("signaling change with CAS off");

	a_sig_chg_read: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_bus.rd && (i_bus.addr == OFF_SIG_CHG0) && !ev[BIT_ABCD])
		|=> (o_rdata == $past(sig_chg[7:0])) && (sig_chg[7:0] == 8'h00))
		else $error("signaling change byte read wrong");

	a_fas_shift_evt: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rx.fas_shift |=> status[BIT_FAS_SHIFT])
		else $error("FAS shift not latched");

	a_oof_change: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_q.oof != $past(s_q.oof)) |-> status[BIT_FRAME_OOF])
		else $error("out-of-frame change not latched");

	a_mimic_crc_evt: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_rx.mimic || i_rx.crc4_err)
		|=> (status[BIT_MIMIC] || !$past(i_rx.mimic))
		&& (status[BIT_CRC4] || !$past(i_rx.crc4_err)))
		else $error("mimic or CRC-4 event not latched");

	a_fas_err_evt: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rx.fas_err |=> status[BIT_FAS_ERR])
		else $error("FAS bit error not latched");

	a_bit_err_sync: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_rx.fas_err && !err_trip && !i_rx.realign && !i_rx.fas_ok)
		|=> (s_q.oof == $past(s_q.oof)))
		else $error("single FAS error moved sync state");

	a_enable_reset: assert property (@(posedge i_clk)
		i_rst |=> (s_q.en == 8'h00) && !o_irq)
		else $error("enable not cleared by reset");

	a_enable_write: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_bus.wr && (i_bus.addr == OFF_IRQ_ENABLE)) ##1 i_bus.rd
		&& (i_bus.addr == OFF_IRQ_ENABLE) |=> (o_rdata == $past(i_bus.wdata, 2)))
		else $error("enable readback wrong");

	a_status_rur: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_bus.rd && (i_bus.addr == OFF_IRQ_STATUS) && (ev == 8'h00))
		|=> (status == 8'h00) && (o_rdata == $past(status)))
		else $error("status not cleared on read");

	a_oof_declare: assert property (@(posedge i_clk) disable iff (i_rst)
		(err_trip && !i_rx.realign && !i_rx.fas_ok) |=> o_oof)
		else $error("out-of-frame not declared at threshold");

	a_irq_level: assert property (@(posedge i_clk) disable iff (i_rst)
		(|(status & s_q.en)) |=> o_irq ##0 (o_irq || !$past(|(status & s_q.en))))
		else $error("interrupt not raised");

	a_irq_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
		!(|(status & s_q.en)) |=> !o_irq)
		else $error("interrupt without enabled status");

	a_rdata_idle: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_bus.rd |=> (o_rdata == 8'h00))
		else $error("read data not zero outside a read");

	a_enable_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		!(i_bus.wr && (i_bus.addr == OFF_IRQ_ENABLE))
		|=> (s_q.en == $past(s_q.en)))
		else $error("enable changed without a write");

	a_status_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
		((ev | status) == 8'h00) |=> (status == 8'h00))
		else $error("status set without an event");

	a_status_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		(!i_bus.rd && !i_bus.wr) |=> ((status & $past(status)) == $past(status)))
		else $error("status bit dropped without a read");

	a_clear_write: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_bus.wr && (i_bus.addr == OFF_IRQ_CLEAR) && (ev == 8'h00))
		|=> ((status & $past(i_bus.wdata)) == 8'h00))
		else $error("clear register did not drop status");

	a_nat_first: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_rx.nat_strobe && !s_q.nat_vld && !status[BIT_NATBIT])
		|=> !status[BIT_NATBIT])
		else $error("first national bit sample raised an event");

	a_abcd_store: assert property (@(posedge i_clk) disable iff (i_rst)
		sig_in_range |=> (s_q.abcd[$past(i_rx.sig_chan)] == $past(i_rx.sig_abcd)))
		else $error("signaling value not stored");

	a_oof_realign: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_rx.realign && s_q.oof) |=> (!o_oof && status[BIT_FRAME_OOF]))
		else $error("realignment did not clear out-of-frame");

	a_fas_ok_count: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_rx.fas_ok && !i_rx.realign) |=> (s_q.err_cnt == 3'h0))
		else $error("good FAS word did not restart the count");

	a_live_state: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_bus.rd && (i_bus.addr == OFF_LIVE_STATE))
		|=> (o_rdata == {6'h00, $past(s_q.mfa_prev), $past(s_q.oof)}))
		else $error("live state read wrong");

endmodule : e1fie_core

`default_nettype wire

// ==== test/tb_top.sv ====
/*
 * Self-checking bench for the receive E1 framer interrupt block: a row table
 * of single events, then hand-written tests for flags, thresholds and reset.
 * Assumes the design files of hdl/ are compiled first.
 */
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import e1fie_pkg::*;

	// One table row: event kind, enable mask, expected status, irq and oof
	typedef struct packed {
		logic [3:0] k;
		logic [7:0] en;
		logic [7:0] st;
		logic       irq;
		logic       oof;
	} e1fie_tb_row_t;

	logic       i_clk;
	logic       i_rst;
	e1fie_bus_t bus;
	e1fie_rx_t  rx;
	logic [7:0] o_rdata;
	logic       o_irq;
	logic       o_oof;
	logic [7:0] d;
	int         n_errors;
	int         checked;
	int         cyc;

	e1fie_tb_row_t rows [13] = '{
		'{4'h7, 8'h80, 8'h80, 1'b1, 1'b0},
		'{4'h7, 8'h00, 8'h80, 1'b0, 1'b0},
		'{4'h6, 8'h40, 8'h40, 1'b1, 1'b0},
		'{4'h6, 8'hbf, 8'h40, 1'b0, 1'b0},
		'{4'h5, 8'h20, 8'h20, 1'b1, 1'b0},
		'{4'h4, 8'h10, 8'h10, 1'b1, 1'b0},
		'{4'h4, 8'hef, 8'h10, 1'b0, 1'b0},
		'{4'h8, 8'h08, 8'h09, 1'b1, 1'b1},
		'{4'h9, 8'h08, 8'h08, 1'b1, 1'b0},
		'{4'h2, 8'h04, 8'h04, 1'b1, 1'b0},
		'{4'h1, 8'h02, 8'h02, 1'b1, 1'b0},
		'{4'h0, 8'h01, 8'h01, 1'b1, 1'b0},
		'{4'h1, 8'hfd, 8'h02, 1'b0, 1'b0}
	};

	e1fie_core e1fie_core_i (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_bus   (bus),
		.i_rx    (rx),
		.o_rdata (o_rdata),
		.o_irq   (o_irq),
		.o_oof   (o_oof)
	);

	// 125 MHz clock
	always #4 i_clk = ~i_clk;

	// Hang guard
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_errors++;
			report_and_stop();
		end
	end

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_clk);
		bus.addr  <= a;
		bus.wdata <= v;
		bus.wr    <= 1'b1;
		@(posedge i_clk);
		bus.wr    <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge i_clk);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge i_clk);
		bus.rd   <= 1'b0;
		#1;
		v = o_rdata;
	endtask : rd

	// Kinds: 0..7 one source each, 3 driving fas_err like 0; 8 three errored FAS words, 9 realign
	task automatic fire(input int k);
		@(posedge i_clk);
		if (k == 0 || k == 8)
		begin
			rx.fas_ok <= 1'b1;
			@(posedge i_clk);
			rx.fas_ok <= 1'b0;
		end
		case (k)
			7: rx.cas_mfa_loss <= ~rx.cas_mfa_loss;
			6:
			begin
				rx.natbits    <= rx.natbits ^ 5'h01;
				rx.nat_strobe <= 1'b1;
			end
			5:
			begin
				rx.sig_abcd   <= rx.sig_abcd ^ 4'h1;
				rx.sig_strobe <= 1'b1;
			end
			4: rx.fas_shift <= 1'b1;
			2: rx.mimic <= 1'b1;
			1: rx.crc4_err <= 1'b1;
			9: rx.realign <= 1'b1;
			default: rx.fas_err <= 1'b1;
		endcase
		if (k == 8)
			repeat (2) @(posedge i_clk);
		@(posedge i_clk);
		rx.nat_strobe <= 1'b0;
		rx.sig_strobe <= 1'b0;
		rx.fas_shift  <= 1'b0;
		rx.fas_err    <= 1'b0;
		rx.realign    <= 1'b0;
		rx.mimic      <= 1'b0;
		rx.crc4_err   <= 1'b0;
	endtask : fire

	// Let an event reach status and the interrupt flop
	task automatic settle();
		repeat (2) @(posedge i_clk);
		#1;
	endtask : settle

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask : end_test

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	initial
	begin
		i_clk = 1'b0;
		i_rst = 1'b1;
		bus = '0;
		rx = '0;
		rx.sig_chan = 5'd7;
		n_errors = 0;
		checked = 0;
		cyc = 0;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		#1;
		chk("irq_rst", {7'h00, o_irq}, 8'h00);
		rd(OFF_IRQ_ENABLE, d);
		chk("enable_rst", d, RST_IRQ_ENABLE);
		// CAS on, default threshold; first national sample is silent
		wr(OFF_FRAME_CTRL, 8'h0b);
		fire(6);
		rd(OFF_IRQ_STATUS, d);
		chk("status_prime", d, 8'h00);
		end_test("reset");

		foreach (rows[i])
		begin
			wr(OFF_IRQ_ENABLE, rows[i].en);
			fire(int'(rows[i].k));
			settle();
			chk("irq_row", {7'h00, o_irq}, {7'h00, rows[i].irq});
			chk("oof_row", {7'h00, o_oof}, {7'h00, rows[i].oof});
			rd(OFF_IRQ_STATUS, d);
			chk("status_row", d, rows[i].st);
			rd(OFF_IRQ_STATUS, d);
			chk("status_cleared", d, 8'h00);
			chk("irq_cleared", {7'h00, o_irq}, 8'h00);
			end_test("row");
		end

		// Per-channel change flags, first and last channel bytes
		rd(OFF_SIG_CHG0, d);
		chk("chg_ch7", d, 8'h80);
		rd(OFF_SIG_CHG0, d);
		chk("chg_ch7_again", d, 8'h00);
		@(posedge i_clk);
		rx.sig_chan <= 5'd29;
		rx.sig_abcd <= 4'h0; // Toggled to 1, unlike the stored 0
		fire(5);
		settle();
		rd(OFF_SIG_CHG0 + 8'h03, d);
		chk("chg_ch29", d, 8'h20);
		rd(OFF_IRQ_STATUS, d);
		end_test("change_flags");

		// CAS off: signaling change gives no interrupt
		wr(OFF_FRAME_CTRL, 8'h03);
		wr(OFF_IRQ_ENABLE, 8'h20);
		fire(5);
		settle();
		chk("irq_cas_off", {7'h00, o_irq}, 8'h00);
		rd(OFF_IRQ_STATUS, d);
		chk("status_cas_off", d, 8'h00);
		end_test("cas_off");

		// Threshold zero acts as one errored word
		wr(OFF_FRAME_CTRL, 8'h00);
		wr(OFF_IRQ_ENABLE, 8'h08);
		fire(0);
		settle();
		chk("oof_thr", {7'h00, o_oof}, 8'h01);
		rd(OFF_LIVE_STATE, d);
		chk("live_oof", d, 8'h01);
		rd(OFF_IRQ_STATUS, d);
		chk("status_thr", d, 8'h09);
		fire(9);
		settle();
		chk("oof_realign", {7'h00, o_oof}, 8'h00);
		rd(OFF_IRQ_STATUS, d);
		end_test("threshold");

		// Clear register, read-only status and unmapped address
		wr(OFF_IRQ_ENABLE, 8'h02);
		fire(1);
		settle();
		chk("irq_before_clr", {7'h00, o_irq}, 8'h01);
		wr(OFF_IRQ_CLEAR, 8'h02);
		wr(OFF_IRQ_STATUS, 8'hff);
		settle();
		chk("irq_after_clr", {7'h00, o_irq}, 8'h00);
		rd(OFF_IRQ_STATUS, d);
		chk("status_after_clr", d, 8'h00);
		rd(8'hff, d);
		chk("unmapped", d, 8'h00);
		end_test("clear");

		// Enable read-back, then reset in mid-run
		// Write then read with no gap between the strobes
		@(posedge i_clk);
		bus.addr  <= OFF_IRQ_ENABLE;
		bus.wdata <= 8'ha5;
		bus.wr    <= 1'b1;
		@(posedge i_clk);
		bus.wr    <= 1'b0;
		bus.rd    <= 1'b1;
		@(posedge i_clk);
		bus.rd    <= 1'b0;
		#1;
		d = o_rdata;
		chk("enable_rw", d, 8'ha5);
		fire(2);
		settle();
		chk("irq_pre_rst", {7'h00, o_irq}, 8'h01);
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		#1;
		chk("irq_mid_rst", {7'h00, o_irq}, 8'h00);
		rd(OFF_IRQ_ENABLE, d);
		chk("enable_mid_rst", d, 8'h00);
		rd(OFF_IRQ_STATUS, d);
		chk("status_mid_rst", d, 8'h00);
		end_test("mid_reset");
		report_and_stop();
	end

endmodule : tb_top

`default_nettype wire
